/* logic/eiec_filter.sv */
// pin synchroniser and width filter for one external interrupt input
`timescale 1ns/1ps
module eiec_filter
    import eiec_pkg::*;
(
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // pin and acceptance width
    input  wire logic             pin,
    input  wire logic [CNT_W-1:0] min_cycles,
    // filtered level
    output logic                  level
);
    logic             sync_a;
    logic             sync_b;
    logic [CNT_W-1:0] stable_cnt;
    wire              differs = sync_b != level;
    wire              accept  = differs && (stable_cnt >= min_cycles - CNT_W'(1));

    // level only moves after the new value held for the full width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            stable_cnt <= '0;
            level <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
            if (!differs || accept) begin
                stable_cnt <= '0;
            end else begin
                stable_cnt <= stable_cnt + CNT_W'(1);
            end
            if (accept) begin
                level <= sync_b;
            end
        end
    end
endmodule

/* logic/eiec_pkg.sv */
// package: register map, fields and timing for the external interrupt edge block
package eiec_pkg;
    // register offsets are word indices; byte address is four times the index
    localparam logic [7:0] GROUP_SEL_INDEX   = 8'h0F;
    localparam logic [7:0] EDGE_SEL_INDEX    = 8'h1F;
    localparam logic [7:0] WIDTH_SEL_INDEX   = 8'h20;
    localparam logic [7:0] REQUEST_INDEX     = 8'h21;
    localparam logic [7:0] ENABLE_INDEX      = 8'h22;
    localparam logic [7:0] LEVEL_INDEX       = 8'h23;
    localparam logic [7:0] IRQ_STATUS_INDEX  = 8'h24;
    localparam logic [7:0] IRQ_MASK_INDEX    = 8'h25;
    localparam logic [7:0] PENDING_INDEX     = 8'h26;
    // edge select fields
    localparam int EDGE_REMOTE_BIT = 0;
    localparam int EDGE_GENERAL_BIT = 1;
    localparam int EDGE_SYNC_BIT = 2;
    // group select fields
    localparam int GRP_TIMER_USE_BIT = 0;
    localparam int GRP_SYNC_SRC_BIT = 1;
    // request/enable/status layout: bit0 remote, bit1 general, bit2 sync, bit3 timer
    localparam int SRC_REMOTE = 0;
    localparam int SRC_GENERAL = 1;
    localparam int SRC_SYNC = 2;
    localparam int SRC_TIMER = 3;
    localparam logic [3:0] REG_RESET = 4'h0;
    localparam logic [3:0] EDGE_SEL_MASK = 4'h7;
    localparam logic [3:0] GROUP_SEL_MASK = 4'h3;
    localparam logic [1:0] WIDTH_SEL_MASK = 2'h3;
    // timing
    localparam int CLK_MHZ = 40;
    localparam int GLITCH_NS = 1000;
    localparam int GLITCH_CYCLES = (GLITCH_NS * CLK_MHZ + 999) / 1000;
    // remote acceptance widths in microseconds, per width select code
    localparam int REMOTE_US_0 = 1;
    localparam int REMOTE_US_1 = 8;
    localparam int REMOTE_US_2 = 32;
    localparam int REMOTE_US_3 = 64;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] REMOTE_CYC_0 = CNT_W'(REMOTE_US_0 * CLK_MHZ);
    localparam logic [CNT_W-1:0] REMOTE_CYC_1 = CNT_W'(REMOTE_US_1 * CLK_MHZ);
    localparam logic [CNT_W-1:0] REMOTE_CYC_2 = CNT_W'(REMOTE_US_2 * CLK_MHZ);
    localparam logic [CNT_W-1:0] REMOTE_CYC_3 = CNT_W'(REMOTE_US_3 * CLK_MHZ);
    localparam logic [CNT_W-1:0] GLITCH_CYC = CNT_W'(GLITCH_CYCLES);
    localparam logic [2:0] PRIO_NONE = 3'h0;
    localparam logic [2:0] PRIO_REMOTE = 3'h1;
    localparam logic [2:0] PRIO_GENERAL = 3'h2;
    localparam logic [2:0] PRIO_SYNC = 3'h7;
endpackage

/* logic/eiec_top.sv */
// external interrupt edge control with APB register access
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module eiec_top
    import eiec_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external pins
    input  wire logic        remote_ctrl_irq_pin,
    input  wire logic        general_irq_pin,
    input  wire logic        vsync_pin,
    input  wire logic        hsync_pin,
    // timer 0 overflow pulse, same clock
    input  wire logic        timer_overflow,
    // toward the cpu interrupt logic
    output logic       [3:0] pending,
    output logic       [2:0] pending_prio,
    output logic             irq
);
    logic [3:0] interrupt_group_select;
    logic [3:0] interrupt_edge_select;
    logic [1:0] remote_width_sel;
    logic [3:0] request_flags;
    logic [3:0] enable_flags;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [2:0] prev_detect;
    logic [2:0] level_flags;

    // filtered pin levels
    logic       remote_level;
    logic       general_level;
    logic       vsync_level;
    logic       hsync_level;
    logic [CNT_W-1:0] remote_min;

    // remote width table
    assign remote_min = (remote_width_sel == 2'h0) ? REMOTE_CYC_0 :
                        (remote_width_sel == 2'h1) ? REMOTE_CYC_1 :
                        (remote_width_sel == 2'h2) ? REMOTE_CYC_2 : REMOTE_CYC_3;

    eiec_filter u_remote (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (remote_ctrl_irq_pin),
        .min_cycles (remote_min),
        .level      (remote_level)
    );
    eiec_filter u_general (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (general_irq_pin),
        .min_cycles (GLITCH_CYC),
        .level      (general_level)
    );
    eiec_filter u_vsync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (vsync_pin),
        .min_cycles (GLITCH_CYC),
        .level      (vsync_level)
    );
    eiec_filter u_hsync (
        .pclk       (pclk),
        .presetn    (presetn),
        .pin        (hsync_pin),
        .min_cycles (GLITCH_CYC),
        .level      (hsync_level)
    );

    wire sync_group_source_sel    = interrupt_group_select[GRP_SYNC_SRC_BIT];
    wire timer_overflow_group_use = interrupt_group_select[GRP_TIMER_USE_BIT];
    wire sync_group_level         = sync_group_source_sel ? hsync_level : vsync_level;
    wire [2:0] current_levels     = {sync_group_level, general_level, remote_level};

    // select bit xor level: select changes look like pin edges
    wire [2:0] detect_in = current_levels ^ {interrupt_edge_select[EDGE_SYNC_BIT],
                                             interrupt_edge_select[EDGE_GENERAL_BIT],
                                             interrupt_edge_select[EDGE_REMOTE_BIT]};
    // rising detect_in = chosen edge: 0 rising, 1 falling
    wire [2:0] pin_edge  = detect_in & ~prev_detect;
    wire       timer_evt = timer_overflow && timer_overflow_group_use;
    wire [3:0] events    = {timer_evt, pin_edge};

    // apb decode, index times four
    wire        apb_access = psel && penable;
    wire        apb_write  = apb_access && pwrite;
    wire [9:0]  word_index = paddr[11:2];
    wire        hit_group  = word_index == {2'h0, GROUP_SEL_INDEX};
    wire        hit_edge   = word_index == {2'h0, EDGE_SEL_INDEX};
    wire        hit_width  = word_index == {2'h0, WIDTH_SEL_INDEX};
    wire        hit_req    = word_index == {2'h0, REQUEST_INDEX};
    wire        hit_enable = word_index == {2'h0, ENABLE_INDEX};
    wire        hit_level  = word_index == {2'h0, LEVEL_INDEX};
    wire        hit_status = word_index == {2'h0, IRQ_STATUS_INDEX};
    wire        hit_mask   = word_index == {2'h0, IRQ_MASK_INDEX};
    wire        hit_pend   = word_index == {2'h0, PENDING_INDEX};
    wire        hit_any    = hit_group | hit_edge | hit_width | hit_req | hit_enable |
                             hit_level | hit_status | hit_mask | hit_pend;
    wire [3:0]  wr_nib     = pwdata[3:0];
    wire [3:0]  req_clear  = (apb_write && hit_req) ? wr_nib : 4'h0;
    wire [3:0]  st_clear   = (apb_write && hit_status) ? wr_nib : 4'h0;

    // set beats clear; no self clearing while polled
    wire [3:0] next_request = (request_flags & ~req_clear) | events;
    wire [3:0] next_status  = (irq_status & ~st_clear) | events;

    // pending needs flag and enable; timer also needs use bit
    wire [3:0] pend_raw = request_flags & enable_flags &
                          {timer_overflow_group_use, 3'h7};
    wire [2:0] next_prio = pend_raw[SRC_REMOTE]  ? PRIO_REMOTE :
                           pend_raw[SRC_GENERAL] ? PRIO_GENERAL :
                           pend_raw[SRC_SYNC]    ? PRIO_SYNC : PRIO_NONE;

    wire [31:0] rd_mux =
        hit_group  ? {28'h0, interrupt_group_select} :
        hit_edge   ? {28'h0, interrupt_edge_select} :
        hit_width  ? {30'h0, remote_width_sel} :
        hit_req    ? {28'h0, request_flags} :
        hit_enable ? {28'h0, enable_flags} :
        hit_level  ? {29'h0, level_flags} :
        hit_status ? {28'h0, irq_status} :
        hit_mask   ? {28'h0, irq_mask} :
        hit_pend   ? {25'h0, pending_prio, pending} : 32'h0;

    // zero wait state slave; unmapped index answers with pslverr
    assign pready  = 1'b1;
    assign pslverr = apb_access && !hit_any;
    assign irq     = |(irq_status & irq_mask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_group_select <= REG_RESET;
            interrupt_edge_select  <= REG_RESET;
            remote_width_sel       <= 2'h0;
            enable_flags           <= REG_RESET;
            irq_mask               <= REG_RESET;
        end else if (apb_write) begin
            // unused bits forced to zero on write
            if (hit_group) interrupt_group_select <= wr_nib & GROUP_SEL_MASK;
            if (hit_edge) interrupt_edge_select <= wr_nib & EDGE_SEL_MASK;
            if (hit_width) remote_width_sel <= pwdata[1:0] & WIDTH_SEL_MASK;
            if (hit_enable) enable_flags <= wr_nib;
            if (hit_mask) irq_mask <= wr_nib;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            request_flags <= REG_RESET;
            irq_status    <= REG_RESET;
            prev_detect   <= 3'h0;
            level_flags   <= 3'h0;
            pending       <= 4'h0;
            pending_prio  <= PRIO_NONE;
            prdata        <= 32'h0;
        end else begin
            request_flags <= next_request;
            irq_status    <= next_status;
            prev_detect   <= detect_in;
            level_flags   <= current_levels;
            pending       <= pend_raw;
            pending_prio  <= next_prio;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end
endmodule

/* tb/eiec_checker.sv */
// port assertions for the external interrupt edge block
`timescale 1ns/1ps
module eiec_checker
    import eiec_pkg::*;
(
    // clock, reset and bus
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and interrupt side
    input wire logic        remote_ctrl_irq_pin,
    input wire logic        general_irq_pin,
    input wire logic        vsync_pin,
    input wire logic        hsync_pin,
    input wire logic        timer_overflow,
    input wire logic [3:0]  pending,
    input wire logic [2:0]  pending_prio,
    input wire logic        irq
);
    wire [9:0] idx = paddr[11:2];
    wire       rsetup = psel && !penable && !pwrite;
    wire       mapped = idx == 10'(GROUP_SEL_INDEX) || idx == 10'(EDGE_SEL_INDEX)
                        || (idx >= 10'(WIDTH_SEL_INDEX) && idx <= 10'(PENDING_INDEX));
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence access_phase;
        psel && penable;
    endsequence
    chk_ready_always: assert property (access_phase |-> pready) else $error("no ready");
    chk_err_unmapped: assert property (access_phase ##0 !mapped |-> pslverr)
        else $error("no error on hole");
    chk_err_mapped: assert property (access_phase ##0 mapped |-> !pslverr)
        else $error("error on register");
    // read data stands between read setups
    chk_rdata_held: assert property (!rsetup |=> $stable(prdata)) else $error("rdata moved");
    chk_prio_remote: assert property (
        pending[0] |-> pending_prio == PRIO_REMOTE) else $error("prio remote");
    chk_prio_general: assert property (
        pending[1:0] == 2'h2 |-> pending_prio == PRIO_GENERAL) else $error("prio general");
    chk_prio_sync: assert property (
        pending[2:0] == 3'h4 |-> pending_prio == PRIO_SYNC) else $error("prio sync");
    chk_prio_none: assert property (
        pending[2:0] == 3'h0 |-> pending_prio == PRIO_NONE) else $error("prio none");
endmodule
bind eiec_top eiec_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remote_ctrl_irq_pin(remote_ctrl_irq_pin),
    .general_irq_pin(general_irq_pin), .vsync_pin(vsync_pin), .hsync_pin(hsync_pin),
    .timer_overflow(timer_overflow), .pending(pending), .pending_prio(pending_prio),
    .irq(irq));

/* tb/eiec_pins.sv */
// far-side pin sources: remote receiver, general interrupt source and two sync generators
`timescale 1ns/1ps
module eiec_pins (
    // pin levels toward the block
    output logic remote_ctrl_irq_pin,
    output logic general_irq_pin,
    output logic vsync_pin,
    output logic hsync_pin
);
    logic [3:0] lvl = 4'h0;
    assign {hsync_pin, vsync_pin, general_irq_pin, remote_ctrl_irq_pin} = lvl;
    // widths come from the bench; short ones probe the filter
    task drive(input int i, input logic v);
        lvl[i] <= v;
    endtask
endmodule

/* tb/eiec_top_test.sv */
// testbench for the external interrupt edge block
`timescale 1ns/1ps
module eiec_top_test;
    import eiec_pkg::*;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic        timer_overflow = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdata;
    logic [3:0]  pending;
    logic [2:0]  pending_prio;
    logic        pready, pslverr, irq, rp, gp, vp, hp;
    int          n_errors = 0;
    int          tests_run = 0;
    always #12.5 pclk = ~pclk;
    eiec_pins pins (.remote_ctrl_irq_pin(rp), .general_irq_pin(gp), .vsync_pin(vp),
        .hsync_pin(hp));
    eiec_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remote_ctrl_irq_pin(rp), .general_irq_pin(gp), .vsync_pin(vp),
        .hsync_pin(hp), .timer_overflow(timer_overflow), .pending(pending),
        .pending_prio(pending_prio), .irq(irq));
    task conclude();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // apb transfer by index; waits on pready with a bound
    task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'h1 && k < 20);
        rdata = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            n_errors++;
            conclude();
        end
        @(posedge pclk);
    endtask
    task rd(input logic [7:0] i, input logic [31:0] e);
        apb(1'h0, i, 32'h0);
        chk(rdata, e);
    endtask
    task clr();
        apb(1'h1, REQUEST_INDEX, 32'hF);
        apb(1'h1, IRQ_STATUS_INDEX, 32'hF);
    endtask
    // high for hi cycles, then low long enough to settle
    task pulse(input int i, input int hi);
        pins.drive(i, 1'h1);
        cyc(hi);
        pins.drive(i, 1'h0);
        cyc(hi + 60);
    endtask
    task tick();
        timer_overflow <= 1'h1;
        @(posedge pclk);
        timer_overflow <= 1'h0;
        cyc(3);
    endtask
    task t_regs();
        rd(GROUP_SEL_INDEX, 32'h0);
        rd(EDGE_SEL_INDEX, 32'h0);
        apb(1'h1, EDGE_SEL_INDEX, 32'hF);
        cyc(4);
        rd(EDGE_SEL_INDEX, 32'h7);
        rd(REQUEST_INDEX, 32'h7);
        apb(1'h1, GROUP_SEL_INDEX, 32'hF);
        rd(GROUP_SEL_INDEX, 32'h3);
        rd(8'h30, 32'h0);
        clr();
        apb(1'h1, EDGE_SEL_INDEX, 32'h0);
        apb(1'h1, GROUP_SEL_INDEX, 32'h0);
        cyc(4);
        rd(REQUEST_INDEX, 32'h0);
        $display("registers done");
    endtask
    task t_edges();
        apb(1'h1, ENABLE_INDEX, 32'hF);
        apb(1'h1, IRQ_MASK_INDEX, 32'hF);
        for (int b = 0; b < 3; b++) begin
            pulse(b, 60);
            chk({31'h0, irq}, 32'h1);
            rd(REQUEST_INDEX, 32'h1 << b);
            clr();
            chk({31'h0, irq}, 32'h0);
        end
        pulse(1, 20);
        rd(REQUEST_INDEX, 32'h0);
        apb(1'h1, EDGE_SEL_INDEX, 32'h2);
        cyc(4);
        clr();
        pins.drive(1, 1'h1);
        cyc(60);
        rd(LEVEL_INDEX, 32'h2);
        rd(REQUEST_INDEX, 32'h0);
        pins.drive(1, 1'h0);
        cyc(60);
        rd(REQUEST_INDEX, 32'h2);
        clr();
        pins.drive(1, 1'h1);
        cyc(60);
        apb(1'h1, EDGE_SEL_INDEX, 32'h0);
        cyc(4);
        rd(REQUEST_INDEX, 32'h2);
        pins.drive(1, 1'h0);
        cyc(60);
        clr();
        $display("edges done");
    endtask
    task t_sync_width();
        apb(1'h1, GROUP_SEL_INDEX, 32'h2);
        pulse(2, 60);
        rd(REQUEST_INDEX, 32'h0);
        pulse(3, 60);
        rd(REQUEST_INDEX, 32'h4);
        apb(1'h1, WIDTH_SEL_INDEX, 32'h1);
        pulse(0, 200);
        rd(REQUEST_INDEX, 32'h4);
        pulse(0, 400);
        rd(REQUEST_INDEX, 32'h5);
        rd(PENDING_INDEX, 32'h15);
        clr();
        $display("sync and width done");
    endtask
    task t_timer();
        apb(1'h1, GROUP_SEL_INDEX, 32'h0);
        tick();
        rd(REQUEST_INDEX, 32'h0);
        apb(1'h1, GROUP_SEL_INDEX, 32'h1);
        apb(1'h1, IRQ_MASK_INDEX, 32'h0);
        tick();
        rd(REQUEST_INDEX, 32'h8);
        chk({28'h0, pending}, 32'h8);
        chk({31'h0, irq}, 32'h0);
        apb(1'h1, ENABLE_INDEX, 32'h7);
        // pending is registered: let the edge that loads it pass first
        cyc(1);
        chk({28'h0, pending}, 32'h0);
        clr();
        $display("timer done");
    endtask
    initial begin
        cyc(2);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_edges();
        t_sync_width();
        t_timer();
        conclude();
    end
endmodule
